// File: radio_cfg_pkg.sv
// Register map, field layout, reset values and timing of the radio config bank
package radio_cfg_pkg;

  // ------------------------------------------------------------
  // Register word indices (byte address is four times the index)
  // ------------------------------------------------------------
  localparam logic [29:0] IDX_SYNC_HI = 30'h0000_df08;
  localparam logic [29:0] IDX_SYNC_LO = 30'h0000_df09;
  localparam logic [29:0] IDX_TX_HI = 30'h0000_df0a;
  localparam logic [29:0] IDX_TX_LO = 30'h0000_df0b;
  localparam logic [29:0] IDX_RX_HI = 30'h0000_df0c;

  // One-hot select positions
  localparam int SEL_SYNC_HI = 0;
  localparam int SEL_SYNC_LO = 1;
  localparam int SEL_TX_HI = 2;
  localparam int SEL_TX_LO = 3;
  localparam int SEL_RX_HI = 4;
  localparam int NUM_REGS = 5;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] RST_SYNC_HI = 8'ha7;
  localparam logic [7:0] RST_SYNC_LO = 8'h0f;
  localparam logic [7:0] RST_TX_HI = 8'ha1;
  localparam logic [7:0] RST_TX_LO = 8'h7f;
  localparam logic [5:0] RST_RX_HI = 6'h12;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int TXH_BUF = 6;
  localparam int TXH_TURN = 5;
  localparam int TXH_VAR = 3;
  localparam int TXH_MIX = 1;
  localparam int TXH_DIFF = 0;
  localparam int TXL_TRIM = 5;
  localparam int TXL_LEVEL = 0;
  localparam int RXH_BUF = 4;
  localparam int RXH_HGC = 2;
  localparam int RXH_MGC = 0;
  localparam int RXH_W = 6;

  // ------------------------------------------------------------
  // Symbol coding and timing
  // ------------------------------------------------------------
  localparam logic [3:0] NIB_ONES = 4'hf;
  localparam logic [3:0] NIB_ZERO = 4'h0;
  localparam logic [1:0] LAST_NIB = 2'h3;
  localparam int CLK_MHZ = 200;
  localparam int SYMBOL_US = 16;
  localparam int TURN_SHORT_US = 128;
  localparam int TURN_LONG_US = 192;
  localparam int SYMBOL_CYCLES = SYMBOL_US * CLK_MHZ;
  localparam logic [3:0] TURN_SHORT_SYM = 4'(TURN_SHORT_US / SYMBOL_US);
  localparam logic [3:0] TURN_LONG_SYM = 4'(TURN_LONG_US / SYMBOL_US);

  // Turnaround states
  typedef enum logic {TURN_IDLE, TURN_WAIT} turn_e;

endpackage : radio_cfg_pkg

// File: radio_sync_and_tx_rx_config.sv
// Radio sync pattern and transmit/receive front end config bank, AHB-Lite slave
`timescale 1ns/1ps
module radio_sync_and_tx_rx_config
  import radio_cfg_pkg::*;
#(
  parameter int SYM_CYC = SYMBOL_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,

  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,

  // Modem transmit side
  input wire logic transmit_on_strobe,
  output logic tx_start,
  output logic symbol_tick,
  output logic [3:0] tx_sym,
  output logic tx_sym_valid,
  output logic tx_busy,

  // Modem receive side
  input wire logic [3:0] rx_sym,
  input wire logic rx_sym_valid,
  output logic frame_sync_found,

  // Static controls
  output logic [15:0] frame_sync_pattern,
  output logic [1:0] tx_mixbuf_bias,
  output logic turnaround_select,
  output logic [1:0] tx_mixer_varactor,
  output logic [1:0] tx_mixer_bias,
  output logic amp_output_select,
  output logic [2:0] amp_current_trim,
  output logic [4:0] amp_output_level,
  output logic [1:0] rx_mixbuf_bias,
  output logic [1:0] high_gain_compensation,
  output logic [1:0] medium_gain_compensation
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] sync_hi;
    logic [7:0] sync_lo;
    logic [7:0] tx_hi;
    logic [7:0] tx_lo;
    logic [RXH_W-1:0] rx_hi;
    logic dp_wr;
    logic [NUM_REGS-1:0] dp_sel;
    logic [31:0] rdata;
    logic ready;
    logic resp;
    logic [15:0] div;
    logic sym_en;
    turn_e turn;
    logic [3:0] turn_cnt;
    logic start;
  } cfg_s;

  cfg_s r;
  cfg_s next_r;
  logic [NUM_REGS-1:0] sel;
  logic take;
  logic [7:0] wbyte;

  sync_if sync ();

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------

  // Word index compare, no match reads zero
  always_comb begin
    sel = '0;
    sel[SEL_SYNC_HI] = (haddr[31:2] == IDX_SYNC_HI);
    sel[SEL_SYNC_LO] = (haddr[31:2] == IDX_SYNC_LO);
    sel[SEL_TX_HI] = (haddr[31:2] == IDX_TX_HI);
    sel[SEL_TX_LO] = (haddr[31:2] == IDX_TX_LO);
    sel[SEL_RX_HI] = (haddr[31:2] == IDX_RX_HI);
  end

  // Address phase taken on NONSEQ or SEQ with hready
  assign take = hsel && htrans[1] && hready;
  assign wbyte = hwdata[7:0];

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.ready = 1'b1;
    next_r.resp = 1'b0;
    next_r.start = 1'b0;
    next_r.sym_en = 1'b0;

    // Data phase write, low byte only
    if (r.dp_wr) begin
      if (r.dp_sel[SEL_SYNC_HI]) begin
        next_r.sync_hi = wbyte;
      end
      if (r.dp_sel[SEL_SYNC_LO]) begin
        next_r.sync_lo = wbyte;
      end
      if (r.dp_sel[SEL_TX_HI]) begin
        next_r.tx_hi = wbyte;
      end
      if (r.dp_sel[SEL_TX_LO]) begin
        next_r.tx_lo = wbyte;
      end
      if (r.dp_sel[SEL_RX_HI]) begin
        next_r.rx_hi = wbyte[RXH_W-1:0];
      end
    end

    // Address phase capture
    next_r.dp_wr = 1'b0;
    next_r.dp_sel = '0;
    if (take) begin
      next_r.dp_wr = hwrite;
      next_r.dp_sel = sel;
    end

    // Read data from post-write values, so write then read is coherent
    if (take && !hwrite) begin
      next_r.rdata = '0;
      if (sel[SEL_SYNC_HI]) begin
        next_r.rdata[7:0] = next_r.sync_hi;
      end
      if (sel[SEL_SYNC_LO]) begin
        next_r.rdata[7:0] = next_r.sync_lo;
      end
      if (sel[SEL_TX_HI]) begin
        next_r.rdata[7:0] = next_r.tx_hi;
      end
      if (sel[SEL_TX_LO]) begin
        next_r.rdata[7:0] = next_r.tx_lo;
      end
      if (sel[SEL_RX_HI]) begin
        next_r.rdata[RXH_W-1:0] = next_r.rx_hi;
      end
    end

    // Symbol tick divider, restarted by an accepted strobe
    if (r.turn == TURN_IDLE && transmit_on_strobe) begin
      next_r.div = '0;
    end else if (r.div == 16'(SYM_CYC - 1)) begin
      next_r.div = '0;
      next_r.sym_en = 1'b1;
    end else begin
      next_r.div = r.div + 16'h0001;
    end

    // Turnaround wait after a transmit-on strobe
    case (r.turn)
      TURN_IDLE: begin
        if (transmit_on_strobe) begin
          next_r.turn = TURN_WAIT;
          next_r.turn_cnt = r.tx_hi[TXH_TURN] ? TURN_LONG_SYM : TURN_SHORT_SYM;
        end
      end
      TURN_WAIT: begin
        if (r.sym_en) begin
          next_r.turn_cnt = r.turn_cnt - 4'h1;
          if (r.turn_cnt == 4'h1) begin
            next_r.turn = TURN_IDLE;
            next_r.start = 1'b1;
          end
        end
      end
      default: begin
        next_r.turn = TURN_IDLE;
      end
    endcase
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
      r.sync_hi <= RST_SYNC_HI;
      r.sync_lo <= RST_SYNC_LO;
      r.tx_hi <= RST_TX_HI;
      r.tx_lo <= RST_TX_LO;
      r.rx_hi <= RST_RX_HI;
      r.ready <= 1'b1;
      r.turn <= TURN_IDLE;
    end else begin
      r <= next_r;
    end
  end

  // ------------------------------------------------------------
  // Sequencers
  // ------------------------------------------------------------
  assign sync.pattern = {r.sync_hi, r.sync_lo};
  assign sync.sym_en = r.sym_en;
  assign sync.tx_start = r.start;
  assign sync.rx_sym = rx_sym;
  assign sync.rx_valid = rx_sym_valid;

  // Transmit nibble walk
  sync_tx_seq u_tx (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .s(sync.tx)
  );

  // Receive pattern match
  sync_rx_det u_rx (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .s(sync.rx)
  );

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------

  // Bus answer, always OKAY and zero wait
  assign hrdata = r.rdata;
  assign hreadyout = r.ready;
  assign hresp = r.resp;

  // Modem handshakes
  assign tx_start = r.start;
  assign symbol_tick = r.sym_en;
  assign tx_sym = sync.tx_sym;
  assign tx_sym_valid = sync.tx_valid;
  assign tx_busy = sync.tx_busy;
  assign frame_sync_found = sync.rx_found;

  // Static controls straight from the register fields
  assign frame_sync_pattern = {r.sync_hi, r.sync_lo};
  assign tx_mixbuf_bias = r.tx_hi[TXH_BUF +: 2];
  assign turnaround_select = r.tx_hi[TXH_TURN];
  assign tx_mixer_varactor = r.tx_hi[TXH_VAR +: 2];
  assign tx_mixer_bias = r.tx_hi[TXH_MIX +: 2];
  assign amp_output_select = r.tx_hi[TXH_DIFF];
  assign amp_current_trim = r.tx_lo[TXL_TRIM +: 3];
  assign amp_output_level = r.tx_lo[TXL_LEVEL +: 5];
  assign rx_mixbuf_bias = r.rx_hi[RXH_BUF +: 2];
  assign high_gain_compensation = r.rx_hi[RXH_HGC +: 2];
  assign medium_gain_compensation = r.rx_hi[RXH_MGC +: 2];

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------

  // Cycles spent waiting since the strobe
  logic [31:0] wait_cyc;
  logic wait_long;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wait_cyc <= '0;
      wait_long <= 1'b0;
    end else if (r.turn == TURN_IDLE && transmit_on_strobe) begin
      wait_cyc <= 32'h0000_0000; // Zero at the strobe edge
      wait_long <= r.tx_hi[TXH_TURN];
    end else begin
      wait_cyc <= wait_cyc + 32'h0000_0001;
    end
  end

  AST_TURN_LEN: assert property (@(posedge ref_clk) disable iff (!rstn)
    $rose(tx_start) |->
    wait_cyc == 32'((wait_long ? TURN_LONG_SYM : TURN_SHORT_SYM) * SYM_CYC + 1))
    else $error("turnaround length wrong");

  AST_RSV_ZERO: assert property (@(posedge ref_clk) disable iff (!rstn)
    (take && !hwrite && sel[SEL_RX_HI]) |=> hrdata[31:RXH_W] == '0)
    else $error("reserved receive bits not zero");

  AST_LEVEL_WR: assert property (@(posedge ref_clk) disable iff (!rstn)
    (r.dp_wr && r.dp_sel[SEL_TX_LO]) |=>
    {amp_current_trim, amp_output_level} == $past(wbyte))
    else $error("amplifier byte not written");

  AST_LEVEL_HOLD: assert property (@(posedge ref_clk) disable iff (!rstn)
    !(r.dp_wr && r.dp_sel[SEL_TX_LO]) |=> $stable(amp_output_level))
    else $error("amplifier level changed without write");

  AST_SYNC_WR: assert property (@(posedge ref_clk) disable iff (!rstn)
    (r.dp_wr && r.dp_sel[SEL_SYNC_HI]) |=>
    frame_sync_pattern[15:8] == $past(wbyte) && $stable(frame_sync_pattern[7:0]))
    else $error("sync high byte write wrong");

  AST_READBACK: assert property (@(posedge ref_clk) disable iff (!rstn)
    (take && !hwrite && sel[SEL_TX_HI] && !r.dp_wr) |=> hrdata[7:0] == r.tx_hi)
    else $error("transmit control readback wrong");

  AST_NO_RESTART: assert property (@(posedge ref_clk) disable iff (!rstn)
    (r.turn == TURN_WAIT && !tx_start) |=> $stable(wait_long))
    else $error("strobe restarted a running wait");

  // Receive byte as stored, reserved bits dropped
  logic [RXH_W-1:0] wfield;
  assign wfield = wbyte[RXH_W-1:0];

  AST_START_PULSE: assert property (@(posedge ref_clk) disable iff (!rstn)
    tx_start |=> !tx_start)
    else $error("turnaround done pulse longer than a cycle");

  AST_SYNC_LO_WR: assert property (@(posedge ref_clk) disable iff (!rstn)
    (r.dp_wr && r.dp_sel[SEL_SYNC_LO]) |=>
    frame_sync_pattern[7:0] == $past(wbyte) && $stable(frame_sync_pattern[15:8]))
    else $error("sync low byte write wrong");

  AST_TX_HI_WR: assert property (@(posedge ref_clk) disable iff (!rstn)
    (r.dp_wr && r.dp_sel[SEL_TX_HI]) |=>
    {tx_mixbuf_bias, turnaround_select, tx_mixer_varactor, tx_mixer_bias,
     amp_output_select} == $past(wbyte))
    else $error("transmit control byte not written");

  AST_RX_WR: assert property (@(posedge ref_clk) disable iff (!rstn)
    (r.dp_wr && r.dp_sel[SEL_RX_HI]) |=>
    {rx_mixbuf_bias, high_gain_compensation, medium_gain_compensation} == $past(wfield))
    else $error("receive control fields not written");

endmodule : radio_sync_and_tx_rx_config

// File: sync_if.sv
// Interface between the config bank and its sync pattern sequencers
`timescale 1ns/1ps
interface sync_if;
  logic [15:0] pattern;
  logic sym_en;
  logic tx_start;
  logic [3:0] tx_sym;
  logic tx_valid;
  logic tx_busy;
  logic [3:0] rx_sym;
  logic rx_valid;
  logic rx_found;
  modport ctl (output pattern, sym_en, tx_start, rx_sym, rx_valid,
               input tx_sym, tx_valid, tx_busy, rx_found);
  modport tx (input pattern, sym_en, tx_start, output tx_sym, tx_valid, tx_busy);
  modport rx (input pattern, rx_sym, rx_valid, output rx_found);
endinterface : sync_if

// File: sync_rx_det.sv
// Receive sync detector over the last five demodulated symbols
`timescale 1ns/1ps
module sync_rx_det
  import radio_cfg_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Detector link
  sync_if.rx s
);

  typedef struct packed {
    logic [19:0] hist;
    logic found;
  } rx_s;

  rx_s r;
  rx_s next_r;
  logic ok;
  int zpos;

  // Shift in symbol, skip all-ones nibbles, need zero ahead
  always_comb begin
    next_r = r;
    next_r.found = 1'b0;
    ok = 1'b1;
    zpos = 4;
    if (s.rx_valid) begin
      next_r.hist = {s.rx_sym, r.hist[19:4]};
      for (int i = 3; i >= 0; i--) begin
        if (s.pattern[i*4 +: 4] != NIB_ONES) begin
          zpos = i;
          if (next_r.hist[(i+1)*4 +: 4] != s.pattern[i*4 +: 4]) begin
            ok = 1'b0;
          end
        end
      end
      if (next_r.hist[zpos*4 +: 4] != NIB_ZERO) begin
        ok = 1'b0;
      end
      next_r.found = ok;
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign s.rx_found = r.found;

  AST_RX_AFTER_SYM: assert property (@(posedge ref_clk) disable iff (!rstn)
    r.found |-> $past(s.rx_valid)) else $error("sync found without a symbol");
  AST_RX_ZERO: assert property (@(posedge ref_clk) disable iff (!rstn)
    (r.found && s.pattern[3:0] != NIB_ONES) |-> r.hist[3:0] == NIB_ZERO)
    else $error("sync found without leading zero");
  AST_RX_TOP: assert property (@(posedge ref_clk) disable iff (!rstn)
    (r.found && s.pattern[15:12] != NIB_ONES) |-> r.hist[19:16] == s.pattern[15:12])
    else $error("sync found with wrong top nibble");

endmodule : sync_rx_det

// File: sync_tx_seq.sv
// Transmit sync pattern sequencer, one nibble per symbol tick
`timescale 1ns/1ps
module sync_tx_seq
  import radio_cfg_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Sequencer link
  sync_if.tx s
);

  typedef struct packed {
    logic active;
    logic [1:0] idx;
    logic [3:0] sym;
    logic valid;
  } tx_s;

  tx_s r;
  tx_s next_r;
  logic [3:0] nib;

  // Walk nibbles low to high, all-ones sent as zero
  always_comb begin
    next_r = r;
    next_r.valid = 1'b0;
    nib = s.pattern[{r.idx, 2'b00} +: 4];
    if (!r.active && s.tx_start) begin
      next_r.active = 1'b1;
      next_r.idx = 2'b00;
    end else if (r.active && s.sym_en) begin
      next_r.sym = (nib == NIB_ONES) ? NIB_ZERO : nib;
      next_r.valid = 1'b1;
      next_r.idx = r.idx + 2'b01;
      next_r.active = (r.idx != LAST_NIB);
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign s.tx_sym = r.sym;
  assign s.tx_valid = r.valid;
  assign s.tx_busy = r.active;

  AST_TX_NO_ONES: assert property (@(posedge ref_clk) disable iff (!rstn)
    r.valid |-> r.sym != NIB_ONES) else $error("all-ones sync nibble sent");
  AST_TX_FIRST: assert property (@(posedge ref_clk) disable iff (!rstn)
    (r.active && r.idx == 2'b00 && s.sym_en) |=>
    r.sym == ((s.pattern[3:0] == NIB_ONES) ? NIB_ZERO : s.pattern[3:0]))
    else $error("first sync nibble is not the low nibble");

endmodule : sync_tx_seq

// File: test_radio_sync_and_tx_rx_config.sv
// Self-checking testbench for the radio sync pattern and front end config bank
`timescale 1ns/1ps
module test_radio_sync_and_tx_rx_config;
  import radio_cfg_pkg::*;

  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  localparam int SYM = 8;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic transmit_on_strobe = 1'b0;
  logic [3:0] rx_sym = 4'h0;
  logic rx_sym_valid = 1'b0;
  wire logic [31:0] hrdata;
  wire logic hreadyout;
  wire logic hresp;
  wire logic tx_start;
  wire logic symbol_tick;
  wire logic [3:0] tx_sym;
  wire logic tx_sym_valid;
  wire logic tx_busy;
  wire logic frame_sync_found;
  wire logic [15:0] frame_sync_pattern;
  wire logic [1:0] tx_mixbuf_bias;
  wire logic turnaround_select;
  wire logic [1:0] tx_mixer_varactor;
  wire logic [1:0] tx_mixer_bias;
  wire logic amp_output_select;
  wire logic [2:0] amp_current_trim;
  wire logic [4:0] amp_output_level;
  wire logic [1:0] rx_mixbuf_bias;
  wire logic [1:0] high_gain_compensation;
  wire logic [1:0] medium_gain_compensation;
  int fail_count = 0;
  int n_tests = 0;

  // Clock, 5 ns period
  always #2.5 ref_clk = ~ref_clk;

  // Single slave, so its ready is the bus ready
  radio_sync_and_tx_rx_config #(.SYM_CYC(SYM)) dut_u (
    .ref_clk(ref_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .transmit_on_strobe(transmit_on_strobe), .tx_start(tx_start), .symbol_tick(symbol_tick),
    .tx_sym(tx_sym), .tx_sym_valid(tx_sym_valid), .tx_busy(tx_busy),
    .rx_sym(rx_sym), .rx_sym_valid(rx_sym_valid), .frame_sync_found(frame_sync_found),
    .frame_sync_pattern(frame_sync_pattern), .tx_mixbuf_bias(tx_mixbuf_bias),
    .turnaround_select(turnaround_select), .tx_mixer_varactor(tx_mixer_varactor),
    .tx_mixer_bias(tx_mixer_bias), .amp_output_select(amp_output_select),
    .amp_current_trim(amp_current_trim), .amp_output_level(amp_output_level),
    .rx_mixbuf_bias(rx_mixbuf_bias), .high_gain_compensation(high_gain_compensation),
    .medium_gain_compensation(medium_gain_compensation)
  );

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  // Verdict and end of run
  task automatic tally_and_finish();
    if (fail_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  // Compare seen against expected
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // A wait that ran out
  task automatic give_up();
    fail_count++;
    tally_and_finish();
  endtask : give_up

  // Byte address of a register word index
  function automatic logic [31:0] addr(input logic [29:0] idx);
    return {idx, 2'b00};
  endfunction : addr

  // One single AHB-Lite transfer, address phase then data phase
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) give_up();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) give_up();
    q = hrdata;
    chk(32'(hresp), 32'h0000_0000);
  endtask : bus

  // Reset pulse of two cycles
  task automatic do_reset();
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
  endtask : do_reset

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  // Reset values through the bus and at the static controls
  task automatic check_resets();
    logic [31:0] q;
    bus(1'b0, addr(IDX_SYNC_HI), 32'h0000_0000, q);
    chk(q, 32'h0000_00a7);
    bus(1'b0, addr(IDX_SYNC_LO), 32'h0000_0000, q);
    chk(q, 32'h0000_000f);
    bus(1'b0, addr(IDX_TX_HI), 32'h0000_0000, q);
    chk(q, 32'h0000_00a1);
    bus(1'b0, addr(IDX_TX_LO), 32'h0000_0000, q);
    chk(q, 32'h0000_007f);
    bus(1'b0, addr(IDX_RX_HI), 32'h0000_0000, q);
    chk(q, 32'h0000_0012);
    chk(32'(frame_sync_pattern), 32'h0000_a70f);
    chk(32'({tx_mixbuf_bias, turnaround_select, tx_mixer_varactor, tx_mixer_bias,
             amp_output_select}), 32'h0000_00a1);
    chk(32'({amp_current_trim, amp_output_level}), 32'h0000_007f);
    chk(32'({rx_mixbuf_bias, high_gain_compensation, medium_gain_compensation}),
        32'h0000_0012);
  endtask : check_resets

  // Write every register and a hole, read each back right after its write
  task automatic write_readback();
    logic [29:0] idx [6];
    logic [31:0] wd [6];
    logic [31:0] rd [6];
    logic [31:0] q;
    idx = '{IDX_SYNC_HI, IDX_SYNC_LO, IDX_TX_HI, IDX_TX_LO, IDX_RX_HI, 30'h0000_df0d};
    wd = '{32'hffff_ffaf, 32'h1234_5670, 32'h0000_005e, 32'h0000_008a, 32'h0000_00ff,
           32'h0000_0055};
    rd = '{32'h0000_00af, 32'h0000_0070, 32'h0000_005e, 32'h0000_008a, 32'h0000_003f,
           32'h0000_0000};
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, addr(idx[i]), wd[i], q);
      bus(1'b0, addr(idx[i]), 32'h0000_0000, q);
      chk(q, rd[i]);
    end
    chk(32'(frame_sync_pattern), 32'h0000_af70);
    chk(32'({tx_mixbuf_bias, turnaround_select, tx_mixer_varactor, tx_mixer_bias,
             amp_output_select}), 32'h0000_005e);
    chk(32'({amp_current_trim, amp_output_level}), 32'h0000_008a);
    chk(32'({rx_mixbuf_bias, high_gain_compensation, medium_gain_compensation}),
        32'h0000_003f);
  endtask : write_readback

  // Strobe, a refused second strobe, turnaround count, then the sent symbols
  task automatic turn(input int n, input logic [15:0] pat);
    int k;
    int j;
    logic [3:0] e;
    logic tk;
    @(posedge ref_clk);
    transmit_on_strobe <= 1'b1;
    @(posedge ref_clk);
    transmit_on_strobe <= 1'b0;
    repeat (3) @(posedge ref_clk);
    transmit_on_strobe <= 1'b1;
    @(posedge ref_clk);
    transmit_on_strobe <= 1'b0;
    k = 4;
    while (k < 300) begin
      @(posedge ref_clk);
      #1;
      k++;
      if (tx_start === 1'b1) break;
    end
    if (k >= 300) give_up();
    chk(32'(k), 32'(n * SYM + 1));
    for (int i = 0; i < 4; i++) begin
      j = 0;
      tk = 1'b0;
      while (j < 100) begin
        @(posedge ref_clk);
        #1;
        j++;
        if (tx_sym_valid === 1'b1) break;
        tk = symbol_tick;
      end
      if (j >= 100) give_up();
      chk(32'(j), 32'(SYM));
      chk(32'(tk), 32'h0000_0001);
      e = pat[4 * i +: 4];
      if (e == 4'hf) e = 4'h0;
      chk(32'(tx_sym), 32'(e));
    end
    chk(32'(tx_busy), 32'h0000_0000);
  endtask : turn

  // Five received symbols, oldest first, then the found pulse
  task automatic rx_try(input logic [19:0] syms, input logic exp);
    for (int i = 0; i < 5; i++) begin
      @(posedge ref_clk);
      rx_sym <= syms[19 - 4 * i -: 4];
      rx_sym_valid <= 1'b1;
    end
    @(posedge ref_clk);
    rx_sym_valid <= 1'b0;
    #1;
    chk(32'(frame_sync_found), 32'(exp));
  endtask : rx_try

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    check_resets();
    turn(12, 16'ha70f);
    rx_try(20'h5_007a, 1'b1);
    rx_try(20'h0_507a, 1'b0);
    rx_try(20'h0_007b, 1'b0);
    write_readback();
    turn(8, 16'haf70);
    rx_try(20'h0_075a, 1'b1);
    rx_try(20'h0_07ca, 1'b1);
    rx_try(20'h3_075a, 1'b0);
    rx_try(20'h0_175a, 1'b0);
    do_reset();
    check_resets();
    tally_and_finish();
  end

endmodule : test_radio_sync_and_tx_rx_config
